// ===== verilog/ilts_top.sv
/*
  ilts_top: interrupt level and trigger setup registers with the
  pending flags that the trigger modes steer.
  assumes: request inputs synchronous to clk_sys; byte offsets 16-bit.
*/
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
module ilts_top
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // avalon-mm
    input  wire logic [16:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // interrupt requests: external group 7..0, internal group 15..8
    input  wire logic [15:0] intReq,
    // configuration towards arbitration
    output logic      [7:0]  extTrigSel,
    output logic      [47:0] prioLevel,
    output logic      [15:0] pendFlag
);
    ilts_bus_if rb ();

    logic [15:0] setupReg [ilts_pkg::NUM_REGS];
    logic [15:0] reqPrev;
    logic [15:0] srcTrig;
    logic [15:0] next_pend;
    logic [15:0] clrMask;

    function automatic logic [15:0] reg_mask(input logic [3:0] idx);
        reg_mask = (idx < 4'h4) ? ilts_pkg::EXT_MASK : ilts_pkg::INT_MASK;
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [15:0] nw,
                                               input logic [1:0]  lane,
                                               input logic [15:0] msk);
        logic [15:0] bm;
        bm = {{8{lane[1]}}, {8{lane[0]}}} & msk;
        lane_merge = (old & ~bm) | (nw & bm);
    endfunction

    ilts_avalon_slave u_slave (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .rb          (rb)
    );

    // setup register writes, reserved bits masked out
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < ilts_pkg::NUM_REGS; i++)
                setupReg[i] <= ilts_pkg::SETUP_RESET;
        end
        else if (rb.wrStb && rb.hit && rb.regIdx < 4'h8)
        begin
            setupReg[rb.regIdx[2:0]] <= lane_merge(setupReg[rb.regIdx[2:0]],
                rb.wrData, rb.wrLane, reg_mask(rb.regIdx));
        end
    end

    // field map per register: low source in [2:0]/4, high in [10:8]/12
    always_comb
    begin
        for (int r = 0; r < 4; r++)
        begin
            extTrigSel[2*r]   = setupReg[r][ilts_pkg::LO_TRIG_POS];
            extTrigSel[2*r+1] = setupReg[r][ilts_pkg::HI_TRIG_POS];
            prioLevel[6*r +: 3] = setupReg[r][ilts_pkg::LO_PRIO_POS +: 3];
            prioLevel[6*r+3 +: 3] = setupReg[r][ilts_pkg::HI_PRIO_POS +: 3];
            prioLevel[24+6*r +: 3] =
                setupReg[r+4][ilts_pkg::LO_PRIO_POS +: 3];
            prioLevel[27+6*r +: 3] =
                setupReg[r+4][ilts_pkg::HI_PRIO_POS +: 3];
        end
    end

    // internal sources are always treated as level requests
    assign srcTrig = {8'hff, extTrigSel};

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            reqPrev <= 16'h0;
        else
            reqPrev <= intReq;
    end

    // software clear only reaches pulse-mode flags
    assign clrMask = (rb.wrStb && rb.hit && rb.flagSel)
                     ? (rb.wrData & ~srcTrig) : 16'h0;

    always_comb
    begin
        for (int k = 0; k < 16; k++)
        begin
            if (srcTrig[k])
                next_pend[k] = intReq[k];
            else
                next_pend[k] = (intReq[k] && !reqPrev[k])
                               || (pendFlag[k] && !clrMask[k]);
        end
    end

    // a new edge wins over a clear arriving in the same cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pendFlag <= 16'h0;
        else
            pendFlag <= next_pend;
    end

    always_comb
    begin
        if (rb.flagSel)
            rb.rdData = pendFlag;
        else if (address[15:0] == ilts_pkg::OFS_SRC)
            rb.rdData = intReq;
        else if (rb.hit && rb.regIdx < 4'h8)
            rb.rdData = setupReg[rb.regIdx[2:0]];
        else
            rb.rdData = 16'h0;
    end

    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        (setupReg[0] & ~ilts_pkg::EXT_MASK) == 16'h0
        && (setupReg[5] & ~ilts_pkg::INT_MASK) == 16'h0)
        else $error("reserved setup bits set");

    a_trig_reset: assert property (@(posedge clk_sys)
        $rose(nrst) |-> extTrigSel == 8'h0)
        else $error("trigger select not zero after reset");

    a_prio_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        rb.wrStb && rb.hit && rb.regIdx == 4'h4 && rb.wrLane[1]
        |=> prioLevel[29:27] == $past(rb.wrData[10:8]))
        else $error("timer16 ch0 level not written");

    a_port1_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        prioLevel[5:3] == setupReg[0][10:8])
        else $error("port1 level misplaced");

    a_ext_map: assert property (@(posedge clk_sys) disable iff (!nrst)
        extTrigSel[3] == setupReg[1][12]
        && extTrigSel[4] == setupReg[2][4]
        && extTrigSel[7] == setupReg[3][12])
        else $error("external trigger bit misplaced");

    a_level_noclr: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        extTrigSel[2] && intReq[2] ##1 extTrigSel[2] |-> pendFlag[2])
        else $error("level flag lost");

    a_pulse_clear: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        clrMask[2] && !(intReq[2] && !reqPrev[2]) |=> !pendFlag[2])
        else $error("pulse flag not cleared");

    a_bus_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
        (read || write) && waitrequest |=> !waitrequest)
        else $error("access not answered in two cycles");

    c_write_setup: cover property (@(posedge clk_sys) disable iff (!nrst)
        rb.wrStb && rb.regIdx == 4'h1);
    c_pulse_clear: cover property (@(posedge clk_sys) disable iff (!nrst)
        clrMask != 16'h0);
    c_level_mode: cover property (@(posedge clk_sys) disable iff (!nrst)
        extTrigSel == 8'hff);
endmodule

// ===== verilog/ilts_pkg.sv
/*
  ilts_pkg: register map, field layout and reset values of the
  interrupt level and trigger setup block.
  assumes: 16-bit registers on a 32-bit avalon-mm word each.
*/
package ilts_pkg;

    // register offsets; every setup register sits on a 16-bit boundary
    localparam logic [15:0] OFS_ELV0 = 16'h4306;
    localparam logic [15:0] OFS_ELV1 = 16'h4308;
    localparam logic [15:0] OFS_ELV2 = 16'h430a;
    localparam logic [15:0] OFS_ELV3 = 16'h430c;
    localparam logic [15:0] OFS_ILV0 = 16'h430e;
    localparam logic [15:0] OFS_ILV1 = 16'h4310;
    localparam logic [15:0] OFS_ILV2 = 16'h4312;
    localparam logic [15:0] OFS_ILV3 = 16'h4314;
    // pending flag and trigger input registers
    localparam logic [15:0] OFS_FLAG = 16'h4300;
    localparam logic [15:0] OFS_SRC  = 16'h4302;

    localparam int NUM_REGS = 8;
    localparam int ADDR_W   = 17;

    // field positions inside one 16-bit setup register
    localparam int LO_PRIO_POS = 0;
    localparam int LO_TRIG_POS = 4;
    localparam int HI_PRIO_POS = 8;
    localparam int HI_TRIG_POS = 12;
    localparam int PRIO_W      = 3;

    localparam logic [15:0] EXT_MASK  = 16'h1717;
    localparam logic [15:0] INT_MASK  = 16'h0707;
    // first external register keeps the port1 trigger bit above the port1 level
    localparam logic [15:0] ELV0_MASK = 16'h1717;

    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [2:0]  PRIO_RESET  = 3'h0;
    localparam logic        TRIG_RESET  = 1'b0;
    localparam logic        TRIG_LEVEL  = 1'b1;

endpackage

// ===== verilog/ilts_bus_if.sv
/*
  ilts_bus_if: internal register access strobes between the bus slave
  and the setup register file.
  assumes: single clock domain, one access per strobe.
*/
`timescale 1ns/10ps
interface ilts_bus_if;
    logic        wrStb;
    logic        rdStb;
    logic [3:0]  regIdx;
    logic        flagSel;
    logic        hit;
    logic [15:0] wrData;
    logic [1:0]  wrLane;
    logic [15:0] rdData;

    modport slave (
        output wrStb, rdStb, regIdx, flagSel, hit, wrData, wrLane,
        input  rdData
    );
    modport regs (
        input  wrStb, rdStb, regIdx, flagSel, hit, wrData, wrLane,
        output rdData
    );
endinterface

// ===== verilog/ilts_avalon_slave.sv
/*
  ilts_avalon_slave: avalon-mm slave front end with waitrequest.
  assumes: master holds the request until waitrequest is sampled low.
  every access answers in the second cycle of the request; read data
  are registered on the first edge so they stand at the accepting edge.
*/
`timescale 1ns/10ps
module ilts_avalon_slave
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // avalon-mm
    input  wire logic [16:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // register file side
    ilts_bus_if.slave        rb
);
    logic        busy;
    logic [15:0] ofs;

    assign ofs = address[15:0];

    // one wait state: the access completes on the second edge
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            busy <= 1'b0;
        else
            busy <= (read || write) && !busy;
    end

    assign waitrequest = (read || write) && !busy;
    assign rb.wrStb   = write && busy;
    assign rb.rdStb   = read && busy;
    assign rb.wrData  = writedata[15:0];
    assign rb.wrLane  = byteenable[1:0];
    assign rb.flagSel = (ofs == ilts_pkg::OFS_FLAG);
    // halfword alignment: the setup registers sit two bytes apart
    assign rb.hit     = !address[16] && (ofs[0] == 1'b0)
                        && ((ofs >= ilts_pkg::OFS_ELV0
                             && ofs <= ilts_pkg::OFS_ILV3)
                            || rb.flagSel || ofs == ilts_pkg::OFS_SRC);
    assign rb.regIdx  = 4'((ofs - ilts_pkg::OFS_ELV0) >> 1);

    // unmapped addresses read zero, bar the flag and source offsets with address bit 16 set; captured in the wait cycle so the
    // word already stands when the master samples waitrequest low
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            readdata <= 32'h0;
        else if (read && !busy)
            readdata <= {16'h0, rb.rdData};
    end
endmodule

// ===== bench/testbench.sv
/*
  testbench: self-checking bench for the level and trigger setup block.
  assumes: ilts_top answers each avalon access after one wait cycle;
  registers sit on 16-bit boundaries; odd offsets are refused.
*/
`timescale 1ns/10ps
module testbench;
    logic        clk_sys    = 1'b0;
    logic        nrst       = 1'b0;
    logic [16:0] address    = 17'h0;
    logic        read       = 1'b0;
    logic        write      = 1'b0;
    logic [31:0] writedata  = 32'h0;
    logic [3:0]  byteenable = 4'h0;
    logic [15:0] intReq     = 16'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [7:0]  extTrigSel;
    logic [47:0] prioLevel;
    logic [15:0] pendFlag;
    logic [15:0] expQ[$];
    logic [15:0] ofsTab[4] = '{ilts_pkg::OFS_ELV1, ilts_pkg::OFS_ELV3,
                               ilts_pkg::OFS_ILV1, ilts_pkg::OFS_ILV3};
    int          loTab[4]  = '{2, 6, 10, 14};
    int          errors    = 0;
    int          checks    = 0;

    always #5 clk_sys = ~clk_sys;

    ilts_top ilts_top_i (
        .clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .intReq(intReq),
        .extTrigSel(extTrigSel), .prioLevel(prioLevel),
        .pendFlag(pendFlag));

    task automatic fail(input string msg);
        errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic final_report;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmpOut(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
            fail($sformatf("output %h, expected %h", got, exp));
    endtask

    task automatic cmpRead(input logic [15:0] exp);
        checks++;
        if (readdata !== {16'h0000, exp})
            fail($sformatf("read %h, expected %h", readdata, exp));
    endtask

    // read data already stand at the accepting edge
    always @(posedge clk_sys)
        if (read === 1'b1 && waitrequest === 1'b0)
        begin
            cmpRead(expQ.pop_front());
        end

    // held until waitrequest is seen low at a rising edge
    task automatic acc(input logic wr, input logic [15:0] ofs,
                       input logic [15:0] d);
        int n;
        n = 0;
        address    <= {1'b0, ofs};
        read       <= ~wr;
        write      <= wr;
        writedata  <= {16'h0000, d};
        byteenable <= 4'h3;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
            fail("no bus answer");
        read  <= 1'b0;
        write <= 1'b0;
        // idle edge so the next request never rises where this one fell
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [15:0] ofs, input logic [15:0] exp);
        expQ.push_back(exp);
        acc(1'b0, ofs, 16'h0000);
    endtask

    function automatic logic [15:0] mask(input int i);
        return (i < 2) ? ilts_pkg::EXT_MASK : ilts_pkg::INT_MASK;
    endfunction

    task automatic wrChk(input int i, input logic [15:0] v);
        logic [15:0] w;
        int          p;
        w = v & mask(i);
        p = 3 * loTab[i];
        acc(1'b1, ofsTab[i], v);
        rd(ofsTab[i], w);
        @(negedge clk_sys);
        cmpOut(16'(prioLevel[p +: 3]), 16'(w[2:0]));
        cmpOut(16'(prioLevel[p + 3 +: 3]), 16'(w[10:8]));
        if (i < 2)
        begin
            cmpOut(16'(extTrigSel[loTab[i]]), 16'(w[4]));
            cmpOut(16'(extTrigSel[loTab[i] + 1]), 16'(w[12]));
        end
        @(posedge clk_sys);
    endtask

    task automatic flagChk(input logic [15:0] exp);
        @(negedge clk_sys);
        cmpOut(pendFlag & 16'h0004, exp);
        @(posedge clk_sys);
    endtask

    initial
    begin
        #100000;
        fail("watchdog expired");
        final_report();
    end

    initial
    begin
        void'($urandom(32'h1124));
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 4; i++)
            rd(ofsTab[i], ilts_pkg::SETUP_RESET);
        for (int r = 0; r < 4; r++)
            for (int i = 0; i < 4; i++)
                wrChk(i, (r == 0) ? 16'hffff : 16'($urandom));
        // odd and unmapped offsets are refused
        acc(1'b1, ilts_pkg::OFS_ELV2, 16'hffff);
        acc(1'b1, 16'h430b, 16'h0000);
        rd(ilts_pkg::OFS_ELV2, 16'h1717);
        rd(16'h4330, 16'h0000);
        rd(16'h4309, 16'h0000);
        @(negedge clk_sys);
        cmpOut(16'(prioLevel[17:12]), 16'h003f);
        cmpOut(16'(extTrigSel[5:4]), 16'h0003);
        @(posedge clk_sys);
        // pulse mode: a short request latches and a one clears it
        acc(1'b1, ilts_pkg::OFS_ELV1, 16'h0000);
        intReq <= 16'h0004;
        @(posedge clk_sys);
        intReq <= 16'h0000;
        repeat (3) @(posedge clk_sys);
        flagChk(16'h0004);
        acc(1'b1, ilts_pkg::OFS_FLAG, 16'h0004);
        flagChk(16'h0000);
        // level mode: the flag ignores a software clear
        acc(1'b1, ilts_pkg::OFS_ELV1, 16'h0010);
        intReq <= 16'h0004;
        repeat (3) @(posedge clk_sys);
        flagChk(16'h0004);
        rd(ilts_pkg::OFS_SRC, 16'h0004);
        acc(1'b1, ilts_pkg::OFS_FLAG, 16'h0004);
        flagChk(16'h0004);
        intReq <= 16'h0000;
        nrst   <= 1'b0;
        @(negedge clk_sys);
        cmpOut(16'(extTrigSel), 16'h0000);
        cmpOut(16'(prioLevel != 48'h0), 16'h0000);
        cmpOut(pendFlag, 16'h0000);
        @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(ilts_pkg::OFS_ELV1, 16'h0000);
        repeat (3) @(posedge clk_sys);
        final_report();
    end
endmodule
